// File: hw/adc_conversion_control.sv
// conversion sequencing, input pairing and range selection
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module adc_conversion_control
  import conv_ctrl_pkg::*;
#(
  parameter int          CONV_LEN  = CONV_TICKS,
  // select 0 first: 0-1 diff, 0/1/2 against 3, then 0..3 single-ended
  parameter logic [47:0] PAIR_MAP  = {6'h32, 6'h22, 6'h12, 6'h02,
                                      6'h2d, 6'h1d, 6'h0d, 6'h04},
  // microvolts per code, gain 0 first; unused codes read as zero
  parameter logic [95:0] LSB_MAP   = 96'h000_000_07d_0fa_1f4_3e8_7d0_bb8
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [3:0]        addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rdata_o,
  input  wire logic [RES_W-1:0]  filter_code_i,
  output logic                   powered_o,
  output logic                   mod_clk_en_o,
  output logic      [1:0]        mux_pos_o,
  output logic      [1:0]        mux_neg_o,
  output logic                   neg_gnd_o,
  output logic      [2:0]        gain_range_field_o,
  output logic                   conv_done_o
);
  typedef enum logic [1:0] {ST_DOWN, ST_CONV, ST_IDLE} conv_st_t;

  typedef struct packed {
    conv_st_t         st;
    logic             mode;
    conv_cfg_t        cfg;
    conv_cfg_t        held;
    logic [10:0]      ticks;
    logic [RES_W-1:0] result;
    logic             done;
    logic [15:0]      rdata;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;
  logic        tick;
  input_pair_t pair_held;

  // table entries are 6 bits: pos, neg, kind
  function automatic input_pair_t decode_pair(input logic [2:0] sel);
    logic [5:0] e;
    e = PAIR_MAP[6*sel +: 6];
    decode_pair = input_pair_t'(e);
  endfunction

  // code weight in microvolts for a gain code
  function automatic logic [11:0] lsb_uv(input logic [2:0] gain);
    lsb_uv = LSB_MAP[12*gain +: 12];
  endfunction

  // a write that lands in the configuration register this cycle
  function automatic logic cfg_write();
    cfg_write = wr_i && (addr_i == ADDR_CFG);
  endfunction

  // single-ended pairings cannot report below zero, so clamp there
  function automatic logic [RES_W-1:0] clamp_code(
    input pair_kind_t       kind,
    input logic [RES_W-1:0] code
  );
    if (kind == PAIR_SINGLE && code[RES_W-1]) begin
      clamp_code = '0;
    end else begin
      clamp_code = code;
    end
  endfunction

  // read mux; the trigger bit always reads back as zero
  function automatic logic [15:0] read_word(input logic [3:0] addr);
    unique case (addr)
      ADDR_CFG:      read_word = {8'h00, s_r.cfg.gain, s_r.cfg.sel,
                                  s_r.mode, 1'b0};
      ADDR_RESULT:   read_word = {s_r.result, 4'h0};
      ADDR_STATUS:   read_word = {14'h0000, s_r.st == ST_CONV,
                                  s_r.st != ST_DOWN};
      ADDR_SETTINGS: read_word = {4'h0, lsb_uv(s_r.held.gain)};
      default:       read_word = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  mod_clock_div #(
    .DIV (MOD_TICK_CYC)
  ) u_div (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (s_r.st == ST_CONV),
    .tick_o  (tick)
  );

  assign pair_held = decode_pair(s_r.held.sel);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic start;
    start = 1'b0;
    s_nxt = s_r;
    // done and read data are one-cycle pulses
    s_nxt.done  = 1'b0;
    s_nxt.rdata = 16'h0000;

    // fields land even mid-conversion, but the held copy keeps the
    // running conversion on its old pairing and range
    if (cfg_write()) begin
      s_nxt.mode     = wdata_i[CFG_MODE_BIT];
      s_nxt.cfg.sel  = wdata_i[CFG_SEL_LSB +: 3];
      s_nxt.cfg.gain = wdata_i[CFG_GAIN_LSB +: 3];
      start          = wdata_i[CFG_TRIG_BIT] || !wdata_i[CFG_MODE_BIT];
    end

    if (rd_i) begin
      s_nxt.rdata = read_word(addr_i);
    end

    unique case (s_r.st)
      ST_DOWN, ST_IDLE: begin
        if (start) begin
          s_nxt.st    = ST_CONV;
          s_nxt.held  = s_nxt.cfg;
          s_nxt.ticks = 11'h000;
        end
      end
      ST_CONV: begin
        // trigger writes here are dropped
        if (tick) begin
          if (s_r.ticks == 11'(CONV_LEN - 1)) begin
            s_nxt.done  = 1'b1;
            s_nxt.ticks = 11'h000;
            s_nxt.result = clamp_code(pair_held.kind, filter_code_i);
            // a mode write during a continuous run stops it here
            if (s_nxt.mode) begin
              s_nxt.st = ST_DOWN;
            end else begin
              s_nxt.held = s_nxt.cfg;
            end
          end else begin
            s_nxt.ticks = s_r.ticks + 11'h001;
          end
        end
      end
      default: s_nxt.st = ST_DOWN;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r       <= '0;
      s_r.st    <= ST_DOWN;
      s_r.mode  <= MODE_RST;
      s_r.cfg   <= '{sel: SEL_RST, gain: GAIN_RST};
      s_r.held  <= '{sel: SEL_RST, gain: GAIN_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rdata_o            = s_r.rdata;
  assign powered_o          = s_r.st == ST_CONV;
  assign mod_clk_en_o       = tick;
  assign mux_pos_o          = pair_held.pos;
  assign mux_neg_o          = pair_held.neg;
  assign neg_gnd_o          = pair_held.kind == PAIR_SINGLE;
  assign gain_range_field_o = s_r.held.gain;
  assign conv_done_o        = s_r.done;
endmodule

// File: hw/conv_ctrl_pkg.sv
// shared constants and types for the conversion control block
package conv_ctrl_pkg;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          OSC_HZ        = 1_000_000;
  localparam int          MOD_DIV       = 4;
  localparam int          MOD_HZ        = OSC_HZ / MOD_DIV;
  localparam int          MOD_TICK_CYC  = CLK_HZ / MOD_HZ;
  localparam int          CONV_TICKS    = 1024;
  localparam int          RES_W         = 12;
  localparam int          CODE_STEPS    = 4096;
  localparam int          FSR_LSB_UV    = 125;
  // register offsets
  localparam logic [3:0]  ADDR_CFG      = 4'h0;
  localparam logic [3:0]  ADDR_RESULT   = 4'h1;
  localparam logic [3:0]  ADDR_STATUS   = 4'h2;
  localparam logic [3:0]  ADDR_SETTINGS = 4'h3;
  // config field positions
  localparam int          CFG_TRIG_BIT  = 0;
  localparam int          CFG_MODE_BIT  = 1;
  localparam int          CFG_SEL_LSB   = 2;
  localparam int          CFG_GAIN_LSB  = 5;
  localparam logic        MODE_RST      = 1'b1;
  localparam logic [2:0]  SEL_RST       = 3'h0;
  localparam logic [2:0]  GAIN_RST      = 3'h2;

  typedef enum logic [1:0] {PAIR_DIFF, PAIR_VS3, PAIR_SINGLE} pair_kind_t;

  typedef struct packed {
    logic [1:0] pos;
    logic [1:0] neg;
    pair_kind_t kind;
  } input_pair_t;

  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] gain;
  } conv_cfg_t;
endpackage

// File: hw/mod_clock_div.sv
// modulator clock enable derived from the core clock
`timescale 1ns/1ps
module mod_clock_div
  import conv_ctrl_pkg::*;
#(
  parameter int DIV = MOD_TICK_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run_i) begin
      st_nxt.cnt = 8'h00;
    end else if (st_r.cnt == 8'(DIV - 1)) begin
      st_nxt.cnt  = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;
endmodule

// File: bench/conv_ctrl_sva.sv
// port assertions for conversion control
`timescale 1ns/1ps
module conv_ctrl_sva
  import conv_ctrl_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        powered_o,
  input wire logic        mod_clk_en_o,
  input wire logic [2:0]  gain_range_field_o,
  input wire logic        conv_done_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // trigger write while idle
  sequence ss_start;
    wr_i && addr_i == ADDR_CFG && wdata_i[1:0] == 2'b11 && !powered_o;
  endsequence
  AST_TRIG_UP: assert property (ss_start |=> powered_o)
    else $error("no power up");
  AST_SS_END:
    assert property (ss_start |-> ##[1:200] conv_done_o ##1 !powered_o)
    else $error("no power down");
  AST_CONT:
    assert property (wr_i && addr_i == ADDR_CFG && wdata_i[1:0] == 2'b00
      |-> ##[1:200] conv_done_o ##1 powered_o) else $error("no restart");
  AST_TICK_PWR: assert property (mod_clk_en_o |-> powered_o)
    else $error("tick while idle");
  // ends of conversion excluded, the divider may restart there
  AST_TICK_GAP:
    assert property (mod_clk_en_o && !conv_done_o ##1 (!conv_done_o)[*8]
      ##32 powered_o |-> mod_clk_en_o) else $error("tick gap");
  AST_DONE_ONE: assert property (conv_done_o |=> !conv_done_o)
    else $error("long done");
  AST_GAIN_HOLD:
    assert property (powered_o && $past(powered_o) && !$past(conv_done_o)
      |-> $stable(gain_range_field_o)) else $error("gain moved");
  AST_RESET: assert property ($fell(rst_i) |-> !powered_o)
    else $error("powered after reset");
endmodule
bind adc_conversion_control conv_ctrl_sva i_conv_ctrl_sva (.*);

// File: bench/filter_model.sv
// filter stand-in giving the conversion code
`timescale 1ns/1ps
module filter_model (
  input  wire logic        clock_i,
  input  wire logic        powered_i,
  input  wire logic [11:0] code_i,
  output logic      [11:0] code_o
);
  // no code is valid while idle, so it toggles
  always_ff @(posedge clock_i) code_o <= powered_i ? code_i : ~code_o;
endmodule

// File: bench/adc_conversion_control_tb.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module adc_conversion_control_tb;
  import conv_ctrl_pkg::*;
  logic        clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0, rdata_o, last;
  logic [11:0] code, code_set = 12'h0;
  logic [2:0]  gain_o, sel;
  logic [1:0]  mp, mn;
  logic        pwr, done, sgl;
  // code weight in microvolts per gain code
  logic [11:0] lsb_tab [8] = '{12'hbb8, 12'h7d0, 12'h3e8, 12'h1f4,
                               12'h0fa, 12'h07d, 12'h000, 12'h000};
  int          bad_count = 0, samples_checked = 0, k;
  // {sel, gain, code}; bit 11 set probes the clamp
  logic [17:0] rows [8] = '{18'h007ff, 18'h09f00, 18'h12123, 18'h1b800,
                            18'h24001, 18'h2dfff, 18'h30456, 18'h39a5a};
  adc_conversion_control #(.CONV_LEN(4)) i_adc_conversion_control (
    .clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .filter_code_i(code), .powered_o(pwr), .mod_clk_en_o(), .mux_pos_o(mp),
    .mux_neg_o(mn), .neg_gnd_o(sgl), .gain_range_field_o(gain_o),
    .conv_done_o(done));
  filter_model i_filter_model (.clock_i, .powered_i(pwr), .code_i(code_set),
    .code_o(code));
  initial forever #50 clock_i = ~clock_i;
  task automatic chk(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) bad_count++;
    if (g !== e) $display("unexpected at %0t: %h not %h", $time, g, e);
  endtask
  task automatic bus(input logic w, logic [3:0] a, logic [15:0] d);
    @(posedge clock_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
    @(posedge clock_i);
    {wr_i, rd_i} <= 2'b00;
    @(negedge clock_i);
    if (!w) chk(rdata_o, d);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wdone;
    for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge clock_i);
    if (k == 400) bad_count++;
    if (k == 400) finish_test;
    @(negedge clock_i);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    bus(1'b0, ADDR_CFG, 16'h0042);
    bus(1'b0, 4'h4, 16'h0);
    foreach (rows[i]) begin
      code_set = rows[i][11:0];
      bus(1'b1, ADDR_CFG, {8'h0, rows[i][14:12], rows[i][17:15], 2'b11});
      @(negedge clock_i);
      chk(gain_o, rows[i][14:12]);
      sel = rows[i][17:15];
      chk(mp, sel[2] ? sel[1:0] : (sel == 3'h0 ? 2'h0 : 2'(sel - 3'h1)));
      chk(mn, sel[2] ? 2'h0 : (sel == 3'h0 ? 2'h1 : 2'h3));
      chk(sgl, sel[2]);
      wdone;
      chk(pwr, 1'b0);
      last = sel[2] & code_set[11] ? 16'h0 : {code_set, 4'h0};
      bus(1'b0, ADDR_RESULT, last);
      bus(1'b0, ADDR_SETTINGS, {4'h0, lsb_tab[rows[i][14:12]]});
    end
    code_set = 12'h222;
    bus(1'b1, ADDR_CFG, 16'h0043);
    bus(1'b1, ADDR_CFG, 16'h0043);
    bus(1'b0, ADDR_RESULT, last);
    bus(1'b0, ADDR_STATUS, 16'h0003);
    wdone;
    repeat (100) @(negedge clock_i);
    chk(pwr, 1'b0);
    bus(1'b0, ADDR_STATUS, 16'h0000);
    bus(1'b0, ADDR_RESULT, 16'h2220);
    bus(1'b1, ADDR_CFG, 16'h0040);
    wdone;
    wdone;
    chk(pwr, 1'b1);
    bus(1'b1, ADDR_CFG, 16'h0042);
    wdone;
    chk(pwr, 1'b0);
    // reset in mid-conversion with non-default settings
    bus(1'b1, ADDR_CFG, 16'h00e7);
    @(posedge clock_i) rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    chk(pwr, 1'b0);
    chk(gain_o, 3'h2);
    bus(1'b0, ADDR_CFG, 16'h0042);
    finish_test;
  end
endmodule
